// File: rtl/ifel_pkg.sv
// constants and types shared by the interrupt flag and enable logic
package ifel_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] IDX_FLAGS0 = 8'h06;
  localparam logic [ADDR_W-1:0] IDX_FLAGS1 = 8'h07;
  localparam logic [ADDR_W-1:0] IDX_EN0 = 8'h08;
  localparam logic [ADDR_W-1:0] IDX_EN1 = 8'h09;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] IDX_MASK = 8'h11;
  localparam int unsigned WORD_BYTES = 4;
  localparam logic [ADDR_W-1:0] ADR_FLAGS0 = ADDR_W'(WORD_BYTES * IDX_FLAGS0);
  localparam logic [ADDR_W-1:0] ADR_FLAGS1 = ADDR_W'(WORD_BYTES * IDX_FLAGS1);
  localparam logic [ADDR_W-1:0] ADR_EN0 = ADDR_W'(WORD_BYTES * IDX_EN0);
  localparam logic [ADDR_W-1:0] ADR_EN1 = ADDR_W'(WORD_BYTES * IDX_EN1);
  localparam logic [ADDR_W-1:0] ADR_STATUS = ADDR_W'(WORD_BYTES * IDX_STATUS);
  localparam logic [ADDR_W-1:0] ADR_MASK = ADDR_W'(WORD_BYTES * IDX_MASK);

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_W = 7;
  localparam int unsigned GRP1_W = 6;
  localparam int unsigned SET_BIT = 7;
  localparam int unsigned GLOBAL_BIT = 6;
  localparam int unsigned CARD_BIT = 5;
  localparam int unsigned TIMER_W = 5;
  localparam int unsigned ERR_BIT = 1;
  localparam int unsigned ERR_W = 5;
  localparam int unsigned INV_BIT = 7;
  localparam int unsigned PUSH_BIT = 7;
  localparam int unsigned PINEN_BIT = 6;
  localparam logic [FLAG_W-1:0] G0_WMASK = 7'h7F;
  localparam logic [FLAG_W-1:0] G1_WMASK = 7'h3F;

  // status register of host-side events, mask has the same layout
  localparam int unsigned ST_W = 3;
  localparam int unsigned ST_GLOBAL = 0;
  localparam int unsigned ST_CARD = 1;
  localparam int unsigned ST_TIMER = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [FLAG_W-1:0] FLAGS_RST = 7'h00;
  localparam logic [REG_W-1:0] EN_RST = 8'h00;
  localparam logic [ST_W-1:0] ST_RST = 3'h0;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // apb slave states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACCESS = 2'b10
  } ifel_apb_state_type;

endpackage

// File: rtl/ifel_flag_if.sv
// carrier between the register front end and one flag bank
`timescale 1ns/1ps
`default_nettype none
interface ifel_flag_if
  import ifel_pkg::*;
();
  logic wr;
  logic set_mode;
  logic [FLAG_W-1:0] wdata;
  logic [FLAG_W-1:0] hw_set;
  logic [FLAG_W-1:0] flags;

  modport bank (
    input wr,
    input set_mode,
    input wdata,
    input hw_set,
    output flags
  );

  modport ctrl (
    output wr,
    output set_mode,
    output wdata,
    output hw_set,
    input flags
  );
endinterface
`default_nettype wire

// File: rtl/ifel_flag_bank.sv
// one bank of sticky event flags with top-bit set/clear writes
`timescale 1ns/1ps
`default_nettype none
module ifel_flag_bank
  import ifel_pkg::*;
#(
  parameter logic [FLAG_W-1:0] WMASK = G0_WMASK
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  ifel_flag_if.bank fl
);

  logic [FLAG_W-1:0] flags_q;
  logic [FLAG_W-1:0] flags_d;
  logic [FLAG_W-1:0] nxt;

  // ----------------------------------------------------------------
  // per-bit next value
  // ----------------------------------------------------------------
  // hardware set wins over a software clear in the same cycle
  for (genvar i = 0; i < FLAG_W; i++)
  begin : g_bit
    logic hit;
    assign hit = fl.wr & fl.wdata[i] & WMASK[i];
    assign nxt[i] = fl.hw_set[i] | (hit ? fl.set_mode : flags_q[i]);
  end

  // next state of the bank
  always_comb
  begin
    flags_d = nxt;
  end

  // flag storage
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      flags_q <= FLAGS_RST;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  assign fl.flags = flags_q;

endmodule
`default_nettype wire

// File: rtl/ifel_top.sv
// interrupt flag and enable logic with apb register access
//
// Behaviour
// - flag word 1 written with top bit one sets flags 5..0 written one
// - flag word 1 written with top bit zero clears flags 5..0 written one
// - global flag bit 6 is set while any enabled flag is set
// - card-detect flag bit 5 is set when card detection finds a card
// - timer flags 4..0 are set on the matching timer underflow
// - enable word 0 bit 7 inverts the interrupt pin level
// - enable word 0 bits 6..0 gate the first flag group into global
// - enable word 1 bits 4..0 gate the timer flags into global
// - enable word 1 bit 5 gates the card-detect flag into global
// - global flag reaches the pin only while enable word 1 bit 6 is one
// - enable word 1 bit 7 selects push-pull, zero selects open-drain
// - flag word 0 uses the same set/clear write over bits 6..0
// - error summary flag is set by any error condition
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ifel_top
  import ifel_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [DATA_W-1:0] PWDATA_I,
  output logic [DATA_W-1:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [FLAG_W-1:0] GROUP0_EVT_I,
  input wire logic [ERR_W-1:0] ERR_COND_I,
  input wire logic CARD_DETECT_I,
  input wire logic [TIMER_W-1:0] TIMER_UFL_I,
  output logic IRQ_PIN_O,
  output logic IRQ_PIN_OE_O,
  output logic IRQ_O
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ifel_apb_state_type state_q;
  ifel_apb_state_type state_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] prdata_d;
  logic [REG_W-1:0] en0_q;
  logic [REG_W-1:0] en0_d;
  logic [REG_W-1:0] en1_q;
  logic [REG_W-1:0] en1_d;
  logic [ST_W-1:0] st_q;
  logic [ST_W-1:0] st_d;
  logic [ST_W-1:0] mask_q;
  logic [ST_W-1:0] mask_d;
  logic global_q;
  logic global_d;
  logic irq_q;
  logic irq_d;
  logic pin_q;
  logic pin_d;
  logic oe_q;
  logic oe_d;
  logic asserted;
  logic hit;
  logic wr_fire;
  logic [REG_W-1:0] rd_word;
  logic [ST_W-1:0] st_evt;
  logic [FLAG_W-1:0] err_set;

  ifel_flag_if fl0 ();
  ifel_flag_if fl1 ();

  // ----------------------------------------------------------------
  // flag banks
  // ----------------------------------------------------------------
  // first group: all seven bits writable
  ifel_flag_bank #(
    .WMASK(G0_WMASK)
  ) u_bank0 (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .fl(fl0.bank)
  );

  // second group: bit 6 is the computed global flag, not stored here
  ifel_flag_bank #(
    .WMASK(G1_WMASK)
  ) u_bank1 (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .fl(fl1.bank)
  );

  // error summary is folded into bit 1 of the first group, shared with group event 1
  always_comb
  begin
    err_set = '0;
    err_set[ERR_BIT] = |ERR_COND_I;
  end

  // write strobes and hardware set terms into the banks
  assign fl0.wr = wr_fire & (PADDR_I == ADR_FLAGS0);
  assign fl0.set_mode = PWDATA_I[SET_BIT];
  assign fl0.wdata = PWDATA_I[FLAG_W-1:0];
  assign fl0.hw_set = GROUP0_EVT_I | err_set;
  assign fl1.wr = wr_fire & (PADDR_I == ADR_FLAGS1);
  assign fl1.set_mode = PWDATA_I[SET_BIT];
  assign fl1.wdata = PWDATA_I[FLAG_W-1:0];
  // bit 6 stays zero: only card detect and timers feed this bank
  assign fl1.hw_set = {1'b0, CARD_DETECT_I, TIMER_UFL_I};

  // ----------------------------------------------------------------
  // apb decode and read mux
  // ----------------------------------------------------------------
  // read data is captured in the setup cycle, so the mux sees live flags
  always_comb
  begin
    hit = 1'b1;
    rd_word = EN_RST;
    case (PADDR_I)
      ADR_FLAGS0:
      begin
        rd_word = {1'b0, fl0.flags};
      end
      ADR_FLAGS1:
      begin
        rd_word = {1'b0, global_q, fl1.flags[GRP1_W-1:0]};
      end
      ADR_EN0:
      begin
        rd_word = en0_q;
      end
      ADR_EN1:
      begin
        rd_word = en1_q;
      end
      ADR_STATUS:
      begin
        rd_word = REG_W'(st_q);
      end
      ADR_MASK:
      begin
        rd_word = REG_W'(mask_q);
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase
  end

  // a write lands only at the edge where the access phase completes
  assign wr_fire = (state_q == ST_ACCESS) & PSEL_I & PENABLE_I & PWRITE_I
                   & pready_q & ~pslverr_q;

  // ----------------------------------------------------------------
  // apb slave state machine
  // ----------------------------------------------------------------
  // zero wait states: ready rises in the first access cycle
  always_comb
  begin
    state_d = state_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    case (state_q)
      ST_IDLE:
      begin
        if (PSEL_I && !PENABLE_I)
        begin
          state_d = ST_ACCESS;
          pready_d = 1'b1;
          pslverr_d = ~hit; // unmapped address answers with an error
          prdata_d = (hit && !PWRITE_I) ? DATA_W'(rd_word) : RDATA_RST;
        end
      end
      ST_ACCESS:
      begin
        state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // bus response registers
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state_q <= ST_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= RDATA_RST;
    end
    else
    begin
      state_q <= state_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // ----------------------------------------------------------------
  // enable and mask registers
  // ----------------------------------------------------------------
  // plain read/write words; they steer the gating and the pin below
  always_comb
  begin
    en0_d = en0_q;
    en1_d = en1_q;
    mask_d = mask_q;
    if (wr_fire && PADDR_I == ADR_EN0)
    begin
      en0_d = PWDATA_I[REG_W-1:0];
    end
    if (wr_fire && PADDR_I == ADR_EN1)
    begin
      en1_d = PWDATA_I[REG_W-1:0];
    end
    if (wr_fire && PADDR_I == ADR_MASK)
    begin
      mask_d = PWDATA_I[ST_W-1:0];
    end
  end

  // configuration storage
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      en0_q <= EN_RST;
      en1_q <= EN_RST;
      mask_q <= ST_RST;
    end
    else
    begin
      en0_q <= en0_d;
      en1_q <= en1_d;
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------------------------------
  // global flag and pin
  // ----------------------------------------------------------------
  // global follows the enabled flags one edge later, never sticky itself
  always_comb
  begin
    global_d = (|(fl0.flags & en0_q[FLAG_W-1:0]))
               | (|(fl1.flags[TIMER_W-1:0] & en1_q[TIMER_W-1:0]))
               | (fl1.flags[CARD_BIT] & en1_q[CARD_BIT]);
    asserted = global_q & en1_q[PINEN_BIT];
    pin_d = asserted ^ en0_q[INV_BIT];
    // open-drain lets go of the pin unless the request is asserted
    oe_d = en1_q[PUSH_BIT] | asserted;
  end

  // pin and global storage
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      global_q <= 1'b0;
      pin_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      global_q <= global_d;
      pin_q <= pin_d;
      oe_q <= oe_d;
    end
  end

  // ----------------------------------------------------------------
  // host event status and interrupt line
  // ----------------------------------------------------------------
  // events: global rising, card found, any timer underflow
  always_comb
  begin
    st_evt = '0;
    st_evt[ST_GLOBAL] = global_d & ~global_q;
    st_evt[ST_CARD] = CARD_DETECT_I;
    st_evt[ST_TIMER] = |TIMER_UFL_I;
    st_d = st_q;
    if (wr_fire && PADDR_I == ADR_STATUS)
    begin
      st_d = st_q & ~PWDATA_I[ST_W-1:0]; // write one to clear
    end
    st_d = st_d | st_evt; // a new event beats the clear
    irq_d = |(st_q & mask_q);
  end

  // status and interrupt storage
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      st_q <= ST_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output is a flip-flop
  assign PRDATA_O = prdata_q;
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign IRQ_PIN_O = pin_q;
  assign IRQ_PIN_OE_O = oe_q;
  assign IRQ_O = irq_q;

endmodule
`default_nettype wire

// File: bench/ifel_top_checker.sv
// bus and reset assertions for the interrupt flag and enable logic
`timescale 1ns/1ps
`default_nettype none
module ifel_top_checker
  import ifel_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [DATA_W-1:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic IRQ_PIN_O,
  input wire logic IRQ_PIN_OE_O,
  input wire logic IRQ_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  logic mapped;
  logic setup;
  // decode kept apart so a stray address shows as an error reply
  assign mapped = PADDR_I inside {ADR_FLAGS0, ADR_FLAGS1, ADR_EN0, ADR_EN1,
    ADR_STATUS, ADR_MASK};
  assign setup = PSEL_I && !PENABLE_I;
  a_ready_after_setup: assert property (setup |=> PREADY_O)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  a_ready_in_access: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
    else $error("ready outside access");
  a_idle_no_ready: assert property (!PSEL_I |=> !PREADY_O)
    else $error("ready while idle");
  a_error_on_decode: assert property (setup |=> PSLVERR_O != $past(mapped))
    else $error("error reply wrong for address");
  a_error_read_zero: assert property (PSLVERR_O |-> PREADY_O && PRDATA_O == 0)
    else $error("error reply with data");
  a_setbit_reads_zero: assert property (PREADY_O && !PWRITE_I &&
    (PADDR_I == ADR_FLAGS0 || PADDR_I == ADR_FLAGS1) |-> !PRDATA_O[7])
    else $error("set control bit read back one");
  a_reset_quiet: assert property ($fell(RST_I) |-> !IRQ_O && !IRQ_PIN_OE_O
    && !PREADY_O && !PSLVERR_O)
    else $error("outputs active after reset");
  c_error_reply: cover property (PSLVERR_O);
  c_irq_raised: cover property (IRQ_O);
  c_pin_low_driven: cover property (IRQ_PIN_OE_O && !IRQ_PIN_O);
endmodule
`default_nettype wire

// File: bench/ifel_host_pin.sv
// host side of the interrupt line: pull-up and level sensing
`timescale 1ns/1ps
`default_nettype none
module ifel_host_pin
(
  input wire logic pin_i,
  input wire logic oe_i,
  output logic level_o
);
  // released line floats to the pull-up level, never to the last value
  assign level_o = oe_i ? pin_i : 1'b1;
endmodule
`default_nettype wire

// File: bench/ifel_top_tb.sv
// self-checking testbench for the interrupt flag and enable logic
`timescale 1ns/1ps
`default_nettype none
module ifel_top_tb
  import ifel_pkg::*;
;
  logic clk, rst, psel, pen, pwr, card, pready, perr, pin, oe, irq, host;
  logic [ADDR_W-1:0] padr;
  logic [DATA_W-1:0] pwd, prd, rdat;
  logic [FLAG_W-1:0] evt;
  logic [ERR_W-1:0] errc;
  logic [TIMER_W-1:0] tmr;
  int n_fail;
  int check_count;
  ifel_top u_ifel_top (.MCLK_I(clk), .RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd),
    .PRDATA_O(prd), .PREADY_O(pready), .PSLVERR_O(perr),
    .GROUP0_EVT_I(evt), .ERR_COND_I(errc), .CARD_DETECT_I(card),
    .TIMER_UFL_I(tmr), .IRQ_PIN_O(pin), .IRQ_PIN_OE_O(oe), .IRQ_O(irq));
  ifel_host_pin u_ifel_host_pin (.pin_i(pin), .oe_i(oe), .level_o(host));
  always #10 clk = ~clk;
  task automatic conclude;
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] s);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // ----------------------------------------------------------------
  // apb master: one transfer, entered and left just after an edge
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
    input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= {24'h00_0000, d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16)
    begin
      n++;
      @(posedge clk);
    end
    if (n >= 16)
    begin
      n_fail++;
      conclude();
    end
    rdat = prd;
    chk("slave error", {7'h00, a == 8'h3C}, {7'h00, perr});
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk("read data", e, rdat[7:0]);
    // only the low byte carries a register; the rest must read zero
    chk("read upper", 8'h00, {7'h00, |rdat[31:8]});
  endtask
  task automatic pulse(input logic [6:0] g, input logic [4:0] e,
    input logic c, input logic [4:0] t);
    evt <= g;
    errc <= e;
    card <= c;
    tmr <= t;
    @(posedge clk);
    evt <= 7'h00;
    errc <= 5'h00;
    card <= 1'b0;
    tmr <= 5'h00;
    repeat (3) @(posedge clk);
  endtask
  // pin drive and host level after the pipeline has settled
  task automatic pinchk(input logic [ADDR_W-1:0] a, input logic [7:0] d,
    input logic e_oe, input logic e_lvl);
    xfer(1'b1, a, d);
    repeat (3) @(posedge clk);
    chk("pin drive", {7'h00, e_oe}, {7'h00, oe});
    chk("host level", {7'h00, e_lvl}, {7'h00, host});
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rdchk(ADR_EN0, 8'h00);
    rdchk(ADR_EN1, 8'h00);
    xfer(1'b1, ADR_EN0, 8'hA5);
    rdchk(ADR_EN0, 8'hA5);
    xfer(1'b1, ADR_EN1, 8'h5A);
    rdchk(ADR_EN1, 8'h5A);
    xfer(1'b1, ADR_EN0, 8'h00);
    xfer(1'b1, ADR_EN1, 8'h00);
    rdchk(8'h3C, 8'h00);
  endtask
  task automatic t_flags;
    xfer(1'b1, ADR_FLAGS0, 8'hFF);
    rdchk(ADR_FLAGS0, 8'h7F);
    xfer(1'b1, ADR_FLAGS0, 8'h7F);
    rdchk(ADR_FLAGS0, 8'h00);
    xfer(1'b1, ADR_FLAGS1, 8'h85);
    rdchk(ADR_FLAGS1, 8'h05);
    xfer(1'b1, ADR_FLAGS1, 8'hBF);
    rdchk(ADR_FLAGS1, 8'h3F);
    xfer(1'b1, ADR_FLAGS1, 8'h03);
    rdchk(ADR_FLAGS1, 8'h3C);
    xfer(1'b1, ADR_FLAGS1, 8'h3C);
    rdchk(ADR_FLAGS1, 8'h00);
  endtask
  task automatic t_events;
    pulse(7'h41, 5'h04, 1'b1, 5'h11);
    rdchk(ADR_FLAGS1, 8'h31);
    rdchk(ADR_FLAGS0, 8'h43);
  endtask
  // global bit follows the enabled flags only
  task automatic t_global;
    xfer(1'b1, ADR_EN1, 8'h10);
    rdchk(ADR_FLAGS1, 8'h71);
    xfer(1'b1, ADR_EN1, 8'h08);
    rdchk(ADR_FLAGS1, 8'h31);
    xfer(1'b1, ADR_EN1, 8'h20);
    rdchk(ADR_FLAGS1, 8'h71);
    xfer(1'b1, ADR_EN1, 8'h00);
    xfer(1'b1, ADR_EN0, 8'h02);
    rdchk(ADR_FLAGS1, 8'h71);
    xfer(1'b1, ADR_EN0, 8'h3C);
    rdchk(ADR_FLAGS1, 8'h31);
  endtask
  task automatic t_pin;
    xfer(1'b1, ADR_EN0, 8'h00);
    pinchk(ADR_EN1, 8'hE0, 1'b1, 1'b1);
    pinchk(ADR_EN0, 8'h80, 1'b1, 1'b0);
    pinchk(ADR_EN1, 8'h60, 1'b1, 1'b0);
    pinchk(ADR_EN1, 8'h40, 1'b0, 1'b1);
    pinchk(ADR_EN1, 8'h80, 1'b1, 1'b1);
    xfer(1'b1, ADR_EN0, 8'h00);
    xfer(1'b1, ADR_EN1, 8'h00);
  endtask
  // sticky status, mask and level interrupt
  task automatic t_irq;
    xfer(1'b1, ADR_STATUS, 8'h07);
    rdchk(ADR_STATUS, 8'h00);
    xfer(1'b1, ADR_MASK, 8'h02);
    pulse(7'h00, 5'h00, 1'b1, 5'h01);
    chk("irq raised", 8'h01, {7'h00, irq});
    rdchk(ADR_STATUS, 8'h06);
    xfer(1'b1, ADR_MASK, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq masked", 8'h00, {7'h00, irq});
    xfer(1'b1, ADR_STATUS, 8'h06);
    rdchk(ADR_STATUS, 8'h00);
  endtask
  // mid-run reset while the line is up: every register back to zero
  task automatic t_reset;
    xfer(1'b1, ADR_MASK, 8'h04);
    xfer(1'b1, ADR_EN1, 8'hE0);
    pulse(7'h00, 5'h00, 1'b0, 5'h02);
    chk("irq before reset", 8'h01, {7'h00, irq});
    chk("drive before reset", 8'h01, {7'h00, oe});
    chk("level before reset", 8'h01, {7'h00, host});
    // global rising and the timer underflow both left a status bit
    rdchk(ADR_STATUS, 8'h05);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("irq after reset", 8'h00, {7'h00, irq});
    chk("drive after reset", 8'h00, {7'h00, oe});
    chk("level after reset", 8'h01, {7'h00, host});
    rdchk(ADR_FLAGS0, 8'h00);
    rdchk(ADR_FLAGS1, 8'h00);
    rdchk(ADR_EN0, 8'h00);
    rdchk(ADR_EN1, 8'h00);
    rdchk(ADR_STATUS, 8'h00);
    rdchk(ADR_MASK, 8'h00);
  endtask
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    {psel, pen, pwr, card} = 4'h0;
    padr = 8'h00;
    pwd = 32'h0000_0000;
    evt = 7'h00;
    errc = 5'h00;
    tmr = 5'h00;
    n_fail = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_regs();
    t_flags();
    t_events();
    t_global();
    t_pin();
    t_irq();
    t_reset();
    conclude();
  end
endmodule
bind ifel_top ifel_top_checker u_ifel_top_checker (.MCLK_I(MCLK_I),
  .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .IRQ_PIN_O(IRQ_PIN_O),
  .IRQ_PIN_OE_O(IRQ_PIN_OE_O), .IRQ_O(IRQ_O));
`default_nettype wire
